// [dma_ctl_defines.svh]
// offsets, field positions, reset values and widths of the channel control block
`ifndef DMA_CTL_DEFINES_SVH
`define DMA_CTL_DEFINES_SVH

// ****************************************************************
// register map, one byte each
// ****************************************************************
`define ADDR_W            3
`define DATA_W            8
`define PTR_W             16
`define OFS_CTL_UPPER     3'h0
`define OFS_CTL_LOWER     3'h1
`define OFS_PTR_BASE      3'h2
`define OFS_SRC_LO        3'h2
`define OFS_SRC_HI        3'h3
`define OFS_DST_LO        3'h4
`define OFS_DST_HI        3'h5
`define OFS_STATUS        3'h6

// ****************************************************************
// control upper byte fields
// ****************************************************************
`define BIT_UNIT_SIZE     7
`define BIT_SRC_STEP_DIR  6
`define BIT_SRC_STEP_EN   5
`define BIT_BLOCK_SIDE    4
`define BIT_BLOCK_EN      3

// ****************************************************************
// control lower byte fields
// ****************************************************************
`define BIT_DST_STEP_DIR  6
`define BIT_DST_STEP_EN   5
`define ACT_SRC_MSB       3

// ****************************************************************
// reset values and pointer steps
// ****************************************************************
`define CTL_UPPER_RST     8'h00
`define CTL_LOWER_RST     8'h00
`define PTR_RST           16'h0000
`define STEP_BYTE         16'h0001
`define STEP_WORD         16'h0002

`endif

// [dma_ctl_pkg.sv]
// types shared by the channel control block
package dma_ctl_pkg;

    // one-hot transfer mode of the channel
    typedef enum logic [2:0] {
        MODE_NORMAL    = 3'b001,
        MODE_BLOCK_DST = 3'b010,
        MODE_BLOCK_SRC = 3'b100
    } mode_t;

endpackage

// [ptr_stepper.sv]
// one address pointer that software loads and each transfer steps
`timescale 1ns/10ps
`include "dma_ctl_defines.svh"

module ptr_stepper (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              load,
    input  wire logic [`PTR_W-1:0] loadVal,
    input  wire logic              step,
    input  wire logic              stepEn,
    input  wire logic              stepDown,
    input  wire logic              word,
    output logic      [`PTR_W-1:0] ptr
);

    logic [`PTR_W-1:0] stepSize;
    logic [`PTR_W-1:0] ptr_nxt;

    assign stepSize = word ? `STEP_WORD : `STEP_BYTE;

    // a software write wins over a step in the same cycle
    always_comb begin
        ptr_nxt = ptr;
        if (load) begin
            ptr_nxt = loadVal;
        end else if (step && stepEn) begin
            ptr_nxt = stepDown ? ptr - stepSize : ptr + stepSize;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr <= `PTR_RST;
        end else begin
            ptr <= ptr_nxt;
        end
    end

    a_ptr_load: assert property (@(posedge clk) disable iff (!nrst)
        load |=> ptr == $past(loadVal))
        else $error("pointer did not take the written value");

    a_ptr_hold: assert property (@(posedge clk) disable iff (!nrst)
        !load && !(step && stepEn) |=> $stable(ptr))
        else $error("pointer moved without a step or a write");

endmodule // ptr_stepper

// [mode_select.sv]
// one-hot transfer mode held in step with the upper control byte
`timescale 1ns/10ps
`include "dma_ctl_defines.svh"

module mode_select (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          blockEn,
    input  wire logic          blockSide,
    output dma_ctl_pkg::mode_t mode,
    output logic               blockMode,
    output logic               srcIsBlock,
    output logic               dstIsBlock
);

    dma_ctl_pkg::mode_t mode_r;
    dma_ctl_pkg::mode_t mode_nxt;

    // inputs are the next register value, so the mode lines up with the register
    always_comb begin
        case ({blockSide, blockEn})
            2'b01: begin
                mode_nxt = dma_ctl_pkg::MODE_BLOCK_DST;
            end
            2'b11: begin
                mode_nxt = dma_ctl_pkg::MODE_BLOCK_SRC;
            end
            default: begin
                mode_nxt = dma_ctl_pkg::MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= dma_ctl_pkg::MODE_NORMAL;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    always_comb begin
        case (mode_r)
            dma_ctl_pkg::MODE_BLOCK_DST: begin
                blockMode  = 1'b1;
                srcIsBlock = 1'b0;
                dstIsBlock = 1'b1;
            end
            dma_ctl_pkg::MODE_BLOCK_SRC: begin
                blockMode  = 1'b1;
                srcIsBlock = 1'b1;
                dstIsBlock = 1'b0;
            end
            default: begin
                blockMode  = 1'b0;
                srcIsBlock = 1'b0;
                dstIsBlock = 1'b0;
            end
        endcase
    end

    assign mode = mode_r;

    a_mode_onehot: assert property (@(posedge clk) disable iff (!nrst)
        $onehot(mode_r))
        else $error("mode state is not one-hot");

endmodule // mode_select

// [dma_chan_ctl.sv]
// control registers, pointer stepping and mode selection for one dma channel
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "dma_ctl_defines.svh"

// ****************************************************************
// Functional notes
// - upper bit 7 picks byte or word
// - source field 01 increments, 11 decrements, else fixed
// - source step is 1 byte, 2 word
// - destination field 01 increments, 11 decrements, else fixed
// - destination step follows size bit: 1 or 2
// - block enable zero means normal mode
// - block side: 01 destination, 11 source
// - all control fields reset to zero
// ****************************************************************

module dma_chan_ctl (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [`ADDR_W-1:0] regAddr,
    input  wire logic [`DATA_W-1:0] regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic      [`DATA_W-1:0] regRdata,
    input  wire logic               xferDone,
    output logic                    wordSize,
    output logic                    blockMode,
    output logic                    srcIsBlock,
    output logic                    dstIsBlock,
    output logic      [`PTR_W-1:0]  srcPtr,
    output logic      [`PTR_W-1:0]  dstPtr,
    output logic      [3:0]         actSource
);

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic [`DATA_W-1:0] ctlUpper_r;
    logic [`DATA_W-1:0] ctlUpper_nxt;
    logic [`DATA_W-1:0] ctlLower_r;
    logic [`DATA_W-1:0] ctlLower_nxt;
    logic               srcStepEn;
    logic               srcStepDown;
    logic               dstStepEn;
    logic               dstStepDown;

    // reserved bits kept
    // reserved positions are stored as written and read back unchanged
    always_comb begin
        ctlUpper_nxt = ctlUpper_r;
        if (regWr && regAddr == `OFS_CTL_UPPER) begin
            ctlUpper_nxt = regWdata;
        end
    end

    always_comb begin
        ctlLower_nxt = ctlLower_r;
        if (regWr && regAddr == `OFS_CTL_LOWER) begin
            ctlLower_nxt = regWdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctlUpper_r <= `CTL_UPPER_RST;
        end else begin
            ctlUpper_r <= ctlUpper_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctlLower_r <= `CTL_LOWER_RST;
        end else begin
            ctlLower_r <= ctlLower_nxt;
        end
    end

    assign wordSize    = ctlUpper_r[`BIT_UNIT_SIZE];
    assign srcStepEn   = ctlUpper_r[`BIT_SRC_STEP_EN];
    assign srcStepDown = ctlUpper_r[`BIT_SRC_STEP_DIR];
    assign dstStepEn   = ctlLower_r[`BIT_DST_STEP_EN];
    assign dstStepDown = ctlLower_r[`BIT_DST_STEP_DIR];
    assign actSource   = ctlLower_r[`ACT_SRC_MSB:0];

    // ****************************************************************
    // address pointers, index 0 source, 1 destination
    // ****************************************************************
    logic [`PTR_W-1:0] ptrQ [2];
    logic [1:0]        ptrLoad;
    logic [1:0]        stepEn;
    logic [1:0]        stepDown;

    assign stepEn   = {dstStepEn, srcStepEn};
    assign stepDown = {dstStepDown, srcStepDown};

    genvar gi;
    for (gi = 0; gi < 2; gi++) begin : g_ptr
        logic              hitLo;
        logic              hitHi;
        logic [`PTR_W-1:0] loadVal;

        assign hitLo       = regWr && (regAddr == `ADDR_W'(`OFS_PTR_BASE + 2 * gi));
        assign hitHi       = regWr && (regAddr == `ADDR_W'(`OFS_PTR_BASE + 2 * gi + 1));
        assign ptrLoad[gi] = hitLo || hitHi;
        // byte writes merge with the half that is not written
        assign loadVal     = hitHi ? {regWdata, ptrQ[gi][7:0]} : {ptrQ[gi][15:8], regWdata};

        ptr_stepper u_ptr (
            .clk      (clk),
            .nrst     (nrst),
            .load     (ptrLoad[gi]),
            .loadVal  (loadVal),
            .step     (xferDone),
            .stepEn   (stepEn[gi]),
            .stepDown (stepDown[gi]),
            .word     (wordSize),
            .ptr      (ptrQ[gi])
        );
    end

    assign srcPtr = ptrQ[0];
    assign dstPtr = ptrQ[1];

    // ****************************************************************
    // transfer mode
    // ****************************************************************
    dma_ctl_pkg::mode_t mode;

    mode_select u_mode (
        .clk        (clk),
        .nrst       (nrst),
        .blockEn    (ctlUpper_nxt[`BIT_BLOCK_EN]),
        .blockSide  (ctlUpper_nxt[`BIT_BLOCK_SIDE]),
        .mode       (mode),
        .blockMode  (blockMode),
        .srcIsBlock (srcIsBlock),
        .dstIsBlock (dstIsBlock)
    );

    // ****************************************************************
    // read port
    // ****************************************************************
    logic [`DATA_W-1:0] rdata_nxt;

    always_comb begin
        case (regAddr)
            `OFS_CTL_UPPER: begin
                rdata_nxt = ctlUpper_r;
            end
            `OFS_CTL_LOWER: begin
                rdata_nxt = ctlLower_r;
            end
            `OFS_SRC_LO: begin
                rdata_nxt = srcPtr[7:0];
            end
            `OFS_SRC_HI: begin
                rdata_nxt = srcPtr[15:8];
            end
            `OFS_DST_LO: begin
                rdata_nxt = dstPtr[7:0];
            end
            `OFS_DST_HI: begin
                rdata_nxt = dstPtr[15:8];
            end
            `OFS_STATUS: begin
                rdata_nxt = {5'h00, mode};
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRd ? rdata_nxt : 8'h00;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_size_write: assert property (
        regWr && regAddr == `OFS_CTL_UPPER |=> wordSize == $past(regWdata[`BIT_UNIT_SIZE]))
        else $error("unit size does not follow the written bit");

    a_src_fixed: assert property (
        xferDone && !ptrLoad[0] && !srcStepEn |=> $stable(srcPtr))
        else $error("fixed source pointer moved");

    a_src_inc: assert property (
        xferDone && !ptrLoad[0] && srcStepEn && !srcStepDown
        |=> srcPtr == `PTR_W'($past(srcPtr) + ($past(wordSize) ? `STEP_WORD : `STEP_BYTE)))
        else $error("source increment wrong");

    a_src_dec: assert property (
        xferDone && !ptrLoad[0] && srcStepEn && srcStepDown
        |=> srcPtr == `PTR_W'($past(srcPtr) - ($past(wordSize) ? `STEP_WORD : `STEP_BYTE)))
        else $error("source decrement wrong");

    a_dst_fixed: assert property (
        xferDone && !ptrLoad[1] && !dstStepEn |=> $stable(dstPtr))
        else $error("fixed destination pointer moved");

    a_dst_inc: assert property (
        xferDone && !ptrLoad[1] && dstStepEn && !dstStepDown
        |=> dstPtr == `PTR_W'($past(dstPtr) + ($past(wordSize) ? `STEP_WORD : `STEP_BYTE)))
        else $error("destination increment wrong");

    a_dst_dec: assert property (
        xferDone && !ptrLoad[1] && dstStepEn && dstStepDown
        |=> dstPtr == `PTR_W'($past(dstPtr) - ($past(wordSize) ? `STEP_WORD : `STEP_BYTE)))
        else $error("destination decrement wrong");

    a_normal_mode: assert property (
        regWr && regAddr == `OFS_CTL_UPPER && !regWdata[`BIT_BLOCK_EN]
        |=> !blockMode && mode == dma_ctl_pkg::MODE_NORMAL)
        else $error("block mode without block enable");

    a_block_side: assert property (
        regWr && regAddr == `OFS_CTL_UPPER && regWdata[`BIT_BLOCK_EN]
        |=> blockMode && srcIsBlock == $past(regWdata[`BIT_BLOCK_SIDE])
            && dstIsBlock == !$past(regWdata[`BIT_BLOCK_SIDE]))
        else $error("block area side wrong");

    a_reset_zero: assert property (disable iff (1'b0)
        $rose(nrst) |-> ctlUpper_r == 8'h00 && ctlLower_r == 8'h00 && !wordSize && !blockMode)
        else $error("control fields not zero after reset");

    a_rdata_idle: assert property (
        !regRd |=> regRdata == 8'h00)
        else $error("read data outside the read cycle");

    a_size_hold: assert property (
        !(regWr && regAddr == `OFS_CTL_UPPER) |=> $stable(wordSize))
        else $error("unit size changed without a write");

    a_mode_hold: assert property (
        !(regWr && regAddr == `OFS_CTL_UPPER) |=> $stable(mode))
        else $error("mode changed without a write");

    // mode matches register
    // the mode state is a second copy of two bits, so it must never drift from them
    a_mode_match: assert property (
        blockMode == ctlUpper_r[`BIT_BLOCK_EN]
        && srcIsBlock == (ctlUpper_r[`BIT_BLOCK_EN] && ctlUpper_r[`BIT_BLOCK_SIDE])
        && dstIsBlock == (ctlUpper_r[`BIT_BLOCK_EN] && !ctlUpper_r[`BIT_BLOCK_SIDE]))
        else $error("mode outputs differ from the control byte");

    a_lower_write: assert property (
        regWr && regAddr == `OFS_CTL_LOWER |=> ctlLower_r == $past(regWdata))
        else $error("lower control byte not stored as written");

    a_upper_read: assert property (
        regRd && regAddr == `OFS_CTL_UPPER |=> regRdata == $past(ctlUpper_r))
        else $error("upper control byte read back wrong");

    // pointer byte write wins
    a_dst_hi_load: assert property (
        regWr && regAddr == `OFS_DST_HI |=> dstPtr[15:8] == $past(regWdata))
        else $error("destination pointer high byte not loaded");

    c_word_inc: cover property (
        xferDone && wordSize && srcStepEn && !srcStepDown ##1 !xferDone);
    c_dst_dec: cover property (
        xferDone && dstStepEn && dstStepDown);
    c_block_src: cover property (
        blockMode && srcIsBlock);
    c_status_read: cover property (
        regRd && regAddr == `OFS_STATUS ##1 regRdata != 8'h00);
    c_block_dst: cover property (
        blockMode && dstIsBlock);

endmodule // dma_chan_ctl

// [dma_chan_ctl_tb.sv]
// self-checking testbench for the dma channel control block
`timescale 1ns/10ps
`include "dma_ctl_defines.svh"

module dma_chan_ctl_tb;

    // ****************************************************************
    // signals and design under test
    // ****************************************************************
    logic               clk;
    logic               nrst;
    logic [`ADDR_W-1:0] regAddr;
    logic [`DATA_W-1:0] regWdata;
    logic               regWr;
    logic               regRd;
    logic [`DATA_W-1:0] regRdata;
    logic               xferDone;
    logic               wordSize;
    logic               blockMode;
    logic               srcIsBlock;
    logic               dstIsBlock;
    logic [`PTR_W-1:0]  srcPtr;
    logic [`PTR_W-1:0]  dstPtr;
    logic [3:0]         actSource;
    int                 mismatches;
    int                 n_compared;

    dma_chan_ctl dut (
        .clk        (clk),
        .nrst       (nrst),
        .regAddr    (regAddr),
        .regWdata   (regWdata),
        .regWr      (regWr),
        .regRd      (regRd),
        .regRdata   (regRdata),
        .xferDone   (xferDone),
        .wordSize   (wordSize),
        .blockMode  (blockMode),
        .srcIsBlock (srcIsBlock),
        .dstIsBlock (dstIsBlock),
        .srcPtr     (srcPtr),
        .dstPtr     (dstPtr),
        .actSource  (actSource)
    );

    initial begin
        clk = 1'b0;
    end

    always #20 clk = ~clk;

    // ****************************************************************
    // bus tasks and comparison
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr    <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] exp, input string what);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        chk({8'h00, regRdata}, {8'h00, exp}, what);
    endtask

    // xferDone held high for n cycles gives n back-to-back steps
    task automatic steps(input int n);
        @(posedge clk);
        xferDone <= 1'b1;
        repeat (n) @(posedge clk);
        xferDone <= 1'b0;
        #1;
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        #400000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        logic [15:0] stp;
        logic [15:0] expS;
        logic [15:0] expD;
        logic [2:0]  expMode;
        logic [1:0]  m;
        mismatches = 0;
        n_compared = 0;
        nrst       = 1'b0;
        regAddr    = 3'h0;
        regWdata   = 8'h00;
        regWr      = 1'b0;
        regRd      = 1'b0;
        xferDone   = 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk({wordSize, blockMode, srcIsBlock, dstIsBlock}, 16'h0000, "reset outputs");
        chk(srcPtr, 16'h0000, "reset source pointer");
        chk(dstPtr, 16'h0000, "reset destination pointer");
        rd(`OFS_CTL_UPPER, 8'h00, "reset upper byte");
        rd(`OFS_CTL_LOWER, 8'h00, "reset lower byte");
        rd(`OFS_STATUS, 8'h01, "reset mode normal");
        rd(3'h7, 8'h00, "unmapped read");
        // word size, source increment, block mode with source area in one write
        wr(`OFS_CTL_UPPER, 8'hb8);
        chk({wordSize, blockMode, srcIsBlock, dstIsBlock}, 16'h000e, "upper b8 outputs");
        rd(`OFS_CTL_UPPER, 8'hb8, "upper readback");
        // every block enable and block side combination
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            expMode = (m[0] == 1'b0) ? 3'b001 : (m[1] ? 3'b100 : 3'b010);
            wr(`OFS_CTL_UPPER, {3'b000, m, 3'b000});
            chk({13'h0000, blockMode, srcIsBlock, dstIsBlock}, {13'h0000, m[0], m == 2'b11, m == 2'b01}, "mode outputs");
            rd(`OFS_STATUS, {5'h00, expMode}, "mode status");
        end
        // reserved positions still store what is written
        wr(`OFS_CTL_UPPER, 8'h07);
        rd(`OFS_CTL_UPPER, 8'h07, "upper reserved bits");
        wr(`OFS_CTL_LOWER, 8'h9f);
        rd(`OFS_CTL_LOWER, 8'h9f, "lower reserved bits");
        chk({12'h000, actSource}, 16'h000f, "activation source");
        wr(3'h7, 8'hff);
        rd(`OFS_CTL_UPPER, 8'h07, "unmapped write ignored");
        // every step code for both sizes, two back-to-back transfers each
        for (int sz = 0; sz < 2; sz++) begin
            for (int c = 0; c < 4; c++) begin
                stp  = (sz == 1) ? `STEP_WORD : `STEP_BYTE;
                expS = 16'h1000;
                expD = 16'h2000;
                if (c == 1) begin
                    expS = expS + 16'(2 * stp);
                    expD = expD + 16'(2 * stp);
                end else if (c == 3) begin
                    expS = expS - 16'(2 * stp);
                    expD = expD - 16'(2 * stp);
                end
                wr(`OFS_SRC_LO, 8'h00);
                wr(`OFS_SRC_HI, 8'h10);
                wr(`OFS_DST_LO, 8'h00);
                wr(`OFS_DST_HI, 8'h20);
                wr(`OFS_CTL_UPPER, {sz[0], c[1:0], 5'h00});
                wr(`OFS_CTL_LOWER, {1'b0, c[1:0], 5'h00});
                chk({15'h0000, wordSize}, {15'h0000, sz[0]}, "size bit");
                steps(2);
                chk(srcPtr, expS, "source pointer step");
                chk(dstPtr, expD, "destination pointer step");
                rd(`OFS_SRC_LO, expS[7:0], "source pointer low readback");
                rd(`OFS_DST_HI, expD[15:8], "destination pointer high readback");
            end
        end
        // decrement across zero wraps the pointer
        wr(`OFS_SRC_LO, 8'h01);
        wr(`OFS_SRC_HI, 8'h00);
        wr(`OFS_CTL_UPPER, 8'he0);
        steps(1);
        chk(srcPtr, 16'hffff, "source pointer wrap");
        // reset in mid-run brings every field back to zero
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk({wordSize, blockMode, srcIsBlock, dstIsBlock}, 16'h0000, "second reset outputs");
        rd(`OFS_CTL_UPPER, 8'h00, "second reset upper");
        rd(`OFS_STATUS, 8'h01, "second reset mode");
        close_out();
    end

endmodule // dma_chan_ctl_tb
